/* timer_irq_dma_enable_status.sv */
// Timer interrupt and DMA request enable register with interrupt status flags
// Behaviour
// [RULE_01] Enable register at 0x0c, 16 bits wide
// [RULE_02] Bit 14 gates trigger DMA requests
// [RULE_03] Bits 12..9 gate channel 4..1 DMA
// [RULE_04] Bit 8 gates update DMA requests
// [RULE_05] Bit 6 gates trigger interrupt
// [RULE_06] Bits 4..1 gate channel 4..1 interrupts
// [RULE_07] Bit 0 gates update interrupt
// [RULE_08] Status at 0x10, bits 15..13 read zero
// [RULE_09] Channel 4 overcapture flag in bit 12
// [RULE_10] Channel 3 overcapture flag in bit 11
// [RULE_11] Recapture while flag set sets overcapture; write-zero clears
// [RULE_12] Match or capture sets channel flag; read clears
// [RULE_13] Trigger and update events set their flags
// [RULE_14] Enables reset zero; reserved zero; irq ORs
//
// The bank sits between the timer core, which pulses raw events, and the
// interrupt and DMA controllers of the chip. Flags are sticky and are kept
// here; DMA requests are taken from the raw events instead, so that one
// event gives exactly one request whatever software does with the flags.
// Set wins over clear in every flag: an event that lands in the cycle of a
// clearing write or of a capture register read is kept, so software sees
// it on its next pass rather than losing it.
// Two words of our own, a block status and its mask, summarise activity
// for a host that does not watch the timer lines itself.
// The host summary bits have their own mask; the interrupt enables play no
// part in them, so the host sees DMA requests (as gated by the DMA enables) and
// overcapture activity even while the timer interrupt is switched off.
// Timing: writes take effect on the next edge, read data stand in the
// cycle after the read strobe, DMA requests follow their event by one
// cycle and the interrupt line follows the flags by one more.
// Limitation: event inputs are single-cycle pulses; a level held high
// sets its flag and issues a DMA request on every cycle it stays high.
// Limitation: a capture register read only clears the channel flag while
// that channel is in input mode; in output mode it is ignored.
`timescale 1ns/1ps
module timer_irq_dma_enable_status
   import timer_irq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [15:0]       reg_rdata,
   input  wire timer_events_s     events,
   input  wire logic [3:0]        ch_input_mode,
   output logic                   timer_irq,
   output dma_req_s               dma_req,
   output logic                   host_irq
);

   // Word select: one compare per register of the bank
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        offset);
      addr_hit = addr == ADDR_W'(offset);
   endfunction

   // Merge a group of per-channel flags or events through their enables
   function automatic logic any_gated(input logic [3:0] flags,
                                      input logic [3:0] enables);
      any_gated = |(flags & enables);
   endfunction

   // Channel event: capture counts in input mode, compare in output mode
   function automatic logic [3:0] ch_event(input logic [3:0] capture,
                                           input logic [3:0] compare,
                                           input logic [3:0] in_mode);
      ch_event = (capture & in_mode) | (compare & ~in_mode);
   endfunction

   // Bits that a write-zero-to-clear access drops; ones leave a flag alone
   function automatic logic [15:0] zero_clears(input logic        wr,
                                               input logic [15:0] wdata);
      zero_clears = {16{wr}} & ~wdata;
   endfunction

   // Address decode; the word is not qualified by the strobes here so the
   // same selects serve the write path and the read mux
   wire              sel_en   = addr_hit(reg_addr, enable_offset);
   wire              sel_st   = addr_hit(reg_addr, status_offset);
   wire              sel_hi   = addr_hit(reg_addr, hostirq_offset);
   wire              sel_hm   = addr_hit(reg_addr, hostmsk_offset);
   wire              wr_en    = reg_wr & sel_en;
   wire              wr_st    = reg_wr & sel_st;
   wire              wr_hi    = reg_wr & sel_hi;
   wire              wr_hm    = reg_wr & sel_hm;

   // Enables act from the edge after the write; an event in the write
   // cycle is still gated by the old value
   // [RULE_01] Enable register storage
   logic [15:0]      enable_q;
   logic [15:0]      enable_d;
   // [RULE_14] Reserved bits masked
   // A write replaces the whole word; reserved bits are dropped on the way
   // in, so they read as zero without a second mask on the read path
   assign enable_d = wr_en ? (reg_wdata & enable_mask) : enable_q;

   // Enable register, resets to zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         enable_q <= enable_reset;
      end else begin
         enable_q <= enable_d;
      end
   end

   // Event decode per flag; a channel only listens to the source that its
   // mode selects, so a stray compare pulse in input mode is ignored
   wire [3:0]        ch_hit   = ch_event(events.capture, events.compare, ch_input_mode);
   // Captures that count, for the overcapture flags and the block status
   wire [3:0]        cap_hit  = events.capture & ch_input_mode;
   wire [3:0]        ch_flag;
   wire [3:0]        ovc_flag;
   wire              upd_flag;
   wire              trig_flag;

   // Software clears a status flag by writing zero to it
   // Writing ones keeps a flag, so software clears one source at a time
   // without racing against events that arrive on the others
   // [RULE_11] Write-zero clear
   wire [15:0]       st_clr   = zero_clears(wr_st, reg_wdata);

   // Both timer-wide flags use the same cell as the channels, so the
   // set-wins behaviour is written once for every timer status flag
   // [RULE_13] Update flag
   flag_cell u_upd (
      .sys_clk (sys_clk),
      .srst    (srst),
      .set_in  (events.update),
      .clr_in  (st_clr[upd_flag_pos]),
      .flag_q  (upd_flag)
   );

   // [RULE_13] Trigger flag
   flag_cell u_trig (
      .sys_clk (sys_clk),
      .srst    (srst),
      .set_in  (events.trigger),
      .clr_in  (st_clr[trig_flag_pos]),
      .flag_q  (trig_flag)
   );

   // Per-channel flags
   // The capture register read clears a flag only in input mode, where the
   // read is how software takes the captured value
   for (genvar i = 0; i < 4; i++) begin : g_ch
      // [RULE_12] Match/capture set, read clears
      flag_cell u_cc (
         .sys_clk (sys_clk),
         .srst    (srst),
         .set_in  (ch_hit[i]),
         .clr_in  (st_clr[ch1_flag_pos+i] | (events.ccr_read[i] & ch_input_mode[i])),
         .flag_q  (ch_flag[i])
      );
      // [RULE_11] Recapture while flag set
      flag_cell u_ov (
         .sys_clk (sys_clk),
         .srst    (srst),
         .set_in  (cap_hit[i] & ch_flag[i]),
         .clr_in  (st_clr[ch1_ovc_pos+i]),
         .flag_q  (ovc_flag[i])
      );
   end

   // Status fields under their own names
   wire              upd_event_flag       = upd_flag;
   wire              trig_event_flag      = trig_flag;
   wire              ch1_event_flag       = ch_flag[0];
   wire              ch1_overcapture_flag = ovc_flag[0];
   wire              ch3_overcapture_flag = ovc_flag[2];
   wire              ch4_overcapture_flag = ovc_flag[3];

   // [RULE_08] Status assembly, reserved bits zero
   // The final mask keeps reserved bits at zero even if a field position
   // is ever moved onto one of them
   logic [15:0]      status_w;
   always_comb begin
      status_w = status_reset;
      status_w[upd_flag_pos] = upd_event_flag;
      status_w[trig_flag_pos] = trig_event_flag;
      status_w[ch1_flag_pos] = ch1_event_flag;
      status_w[ch1_flag_pos+1 +: 3] = ch_flag[3:1];
      status_w[ch1_ovc_pos] = ch1_overcapture_flag;
      status_w[ch1_ovc_pos+1] = ovc_flag[1];
      // [RULE_10] Channel 3 overcapture in bit 11
      status_w[ch1_ovc_pos+2] = ch3_overcapture_flag;
      // [RULE_09] Channel 4 overcapture in bit 12
      status_w[ch1_ovc_pos+3] = ch4_overcapture_flag;
      status_w = status_w & status_mask;
   end

   // [RULE_02] [RULE_03] [RULE_04] Named DMA enable fields
   wire              trig_dma_en = enable_q[trig_dma_pos];
   wire              ch4_dma_en  = enable_q[ch1_dma_pos+3];
   wire              ch3_dma_en  = enable_q[ch1_dma_pos+2];
   wire              ch2_dma_en  = enable_q[ch1_dma_pos+1];
   wire              ch1_dma_en  = enable_q[ch1_dma_pos];
   wire              upd_dma_en  = enable_q[upd_dma_pos];
   wire [3:0]        ch_dma_en   = {ch4_dma_en, ch3_dma_en, ch2_dma_en, ch1_dma_en};

   // [RULE_05] [RULE_06] [RULE_07] Named interrupt enable fields
   wire              trig_irq_en = enable_q[trig_irq_pos];
   wire              ch4_irq_en  = enable_q[ch1_irq_pos+3];
   wire              ch3_irq_en  = enable_q[ch1_irq_pos+2];
   wire              ch2_irq_en  = enable_q[ch1_irq_pos+1];
   wire              ch1_irq_en  = enable_q[ch1_irq_pos];
   wire              upd_irq_en  = enable_q[upd_irq_pos];
   wire [3:0]        ch_irq_en   = {ch4_irq_en, ch3_irq_en, ch2_irq_en, ch1_irq_en};

   // [RULE_05] [RULE_06] [RULE_07] Interrupt gating
   // [RULE_14] Irq is OR of enabled flags
   // The line follows the flags, not the raw events, so it stays up until
   // software has cleared every enabled flag that is set
   wire              upd_irq_hit  = upd_flag & upd_irq_en;
   wire              trig_irq_hit = trig_flag & trig_irq_en;
   wire              ch_irq_hit   = any_gated(ch_flag, ch_irq_en);
   wire              irq_d        = upd_irq_hit | trig_irq_hit | ch_irq_hit;

   // [RULE_02] [RULE_03] [RULE_04] DMA gating on raw events
   // Raw events rather than flags: one request per event, and a flag that
   // software leaves set does not keep the DMA controller busy
   dma_req_s         dma_d;
   // Field order of the carrier: update, trigger, channels 4..1
   assign dma_d = {events.update & upd_dma_en,
                   events.trigger & trig_dma_en,
                   ch_hit & ch_dma_en};

   // Block events: any DMA request issued, any overcapture seen
   // Overcapture is taken from the same gated capture that sets the
   // channel's own overcapture flag, so both always agree
   wire [1:0]        hev;
   assign hev[ev_dma_pos] = |dma_d;
   assign hev[ev_ovc_pos] = any_gated(cap_hit, ch_flag);

   // Block sticky status, write one to clear, set wins
   // Write-one-to-clear here, unlike the timer status word, so a host can
   // acknowledge one summary bit without a read-modify-write
   logic [1:0]       hstat_q;
   logic [1:0]       hstat_d;
   logic [1:0]       hmask_q;
   logic [1:0]       hmask_d;
   wire  [1:0]       hstat_clr = {2{wr_hi}} & reg_wdata[1:0];
   assign hstat_d = hev | (hstat_q & ~hstat_clr);
   assign hmask_d = wr_hm ? reg_wdata[1:0] : hmask_q;

   // Read mux, unmapped reads as zero
   // Zero outside the read slot as well, so a bus that ORs the read data
   // of several slaves needs no extra gating
   logic [15:0]      rdata_d;
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         if (sel_en) begin
            rdata_d = enable_q;
         end else if (sel_st) begin
            rdata_d = status_w;
         end else if (sel_hi) begin
            rdata_d = {14'h0000, hstat_q};
         end else if (sel_hm) begin
            rdata_d = {14'h0000, hmask_q};
         end
      end
   end

   // Read data register, valid only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // Request registers; requests land one cycle after the event
   // Registered so that no output glitches while enables are rewritten
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_irq <= 1'b0;
         dma_req   <= '0;
      end else begin
         timer_irq <= irq_d;
         dma_req   <= dma_d;
      end
   end

   // Block status, mask and summary interrupt
   // The summary lags the status by one more cycle, as the read data do; a host
   // that polls the status word sees an event no earlier than the cycle the line
   // rises, and the bit stays set until it is acknowledged
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hstat_q  <= hostirq_reset;
         hmask_q  <= hostirq_reset;
         host_irq <= 1'b0;
      end else begin
         hstat_q  <= hstat_d;
         hmask_q  <= hmask_d;
         host_irq <= |(hstat_q & hmask_q);
      end
   end
endmodule

/* timer_irq_pkg.sv */
// Package with offsets, field positions and carriers of the timer interrupt/DMA enable bank
package timer_irq_pkg;
   localparam logic [7:0]  enable_offset  = 8'h0c;
   localparam logic [7:0]  status_offset  = 8'h10;
   localparam logic [7:0]  hostirq_offset = 8'h18;
   localparam logic [7:0]  hostmsk_offset = 8'h1c;
   // Enable register fields
   localparam int          upd_irq_pos    = 0;
   localparam int          ch1_irq_pos    = 1;
   localparam int          trig_irq_pos   = 6;
   localparam int          upd_dma_pos    = 8;
   localparam int          ch1_dma_pos    = 9;
   localparam int          trig_dma_pos   = 14;
   localparam logic [15:0] enable_mask    = 16'h5f5f;
   localparam logic [15:0] enable_reset   = 16'h0000;
   // Status register fields
   localparam int          upd_flag_pos   = 0;
   localparam int          ch1_flag_pos   = 1;
   localparam int          trig_flag_pos  = 6;
   localparam int          ch1_ovc_pos    = 9;
   localparam logic [15:0] status_mask    = 16'h1e5f;
   localparam logic [15:0] status_reset   = 16'h0000;
   // Block-level event sticky bits
   localparam int          ev_dma_pos     = 0;
   localparam int          ev_ovc_pos     = 1;
   localparam logic [1:0]  hostirq_reset  = 2'h0;

   typedef struct packed {
      logic       update;
      logic       trigger;
      logic [3:0] capture;
      logic [3:0] compare;
      logic [3:0] ccr_read;
   } timer_events_s;

   typedef struct packed {
      logic       upd;
      logic       trig;
      logic [3:0] ch;
   } dma_req_s;
endpackage

/* flag_cell.sv */
// One sticky status flag: hardware set wins over a software clear
`timescale 1ns/1ps
module flag_cell (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic set_in,
   input  wire logic clr_in,
   output logic      flag_q
);
   logic flag_d;

   // Set has priority so an event in the clear cycle survives
   assign flag_d = set_in | (flag_q & ~clr_in);

   // Flag register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule

/* timer_irq_checker.sv */
// Port assertions for the timer interrupt and DMA enable bank
`timescale 1ns/1ps
module timer_irq_checker
   import timer_irq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic              sys_clk,
   input wire logic              srst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [15:0]       reg_rdata,
   input wire timer_events_s     events,
   input wire logic [3:0]        ch_input_mode,
   input wire logic              timer_irq,
   input wire dma_req_s          dma_req,
   input wire logic              host_irq
);
   logic [15:0] en_q;
   wire  [3:0]  ch_ev;
   // Shadow of the enable register; reserved bits never stick
   always_ff @(posedge sys_clk) begin
      if (srst) en_q <= 16'h0000;
      else if (reg_wr && reg_addr == enable_offset) en_q <= reg_wdata & enable_mask;
   end
   // Capture counts in input mode, compare in output mode
   assign ch_ev = (events.capture & ch_input_mode) | (events.compare & ~ch_input_mode);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   upd_dma_a: assert property (dma_req.upd == $past(events.update & en_q[8]))
      else $error("update DMA request wrong");
   trig_dma_a: assert property (dma_req.trig == $past(events.trigger & en_q[14]))
      else $error("trigger DMA request wrong");
   ch_dma_a: assert property (dma_req.ch == $past(ch_ev & en_q[12:9]))
      else $error("channel DMA request wrong");
   en_read_a: assert property (reg_rd && reg_addr == enable_offset |=> reg_rdata == $past(en_q))
      else $error("enable readback wrong");
   st_resv_a: assert property (reg_rd && reg_addr == status_offset |=> reg_rdata[15:13] == 3'h0)
      else $error("status reserved bits set");
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   irq_off_a: assert property (en_q[6:0] == 7'h00 |=> !timer_irq)
      else $error("interrupt with all enables off");
   upd_irq_a: assert property (events.update && en_q[0] |-> ##[1:3] timer_irq)
      else $error("update interrupt missing");
   trig_irq_a: assert property (events.trigger && en_q[6] |-> ##[1:3] timer_irq)
      else $error("trigger interrupt missing");
   ch_irq_a: assert property ((ch_ev & en_q[4:1]) != 4'h0 |-> ##[1:3] timer_irq)
      else $error("channel interrupt missing");
   cover property (dma_req.upd);
   cover property ($rose(timer_irq));
   cover property ($rose(host_irq));
endmodule
bind timer_irq_dma_enable_status timer_irq_checker #(.ADDR_W(ADDR_W)) i_chk (
   .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events),
   .ch_input_mode(ch_input_mode), .timer_irq(timer_irq), .dma_req(dma_req),
   .host_irq(host_irq));

/* dma_sink_model.sv */
// DMA controller side: counts every request pulse by kind
`timescale 1ns/1ps
module dma_sink_model
   import timer_irq_pkg::*;
(
   input  wire logic     sys_clk,
   input  wire logic     srst,
   input  wire dma_req_s dma_req,
   output logic [7:0]    n_upd,
   output logic [7:0]    n_trig,
   output logic [7:0]    n_ch
);
   // Pulses are one cycle, so each sampled high is one request
   always_ff @(posedge sys_clk) begin
      if (srst) {n_upd, n_trig, n_ch} <= 24'h000000;
      else begin
         n_upd  <= n_upd + 8'(dma_req.upd);
         n_trig <= n_trig + 8'(dma_req.trig);
         n_ch   <= n_ch + 8'($countones(dma_req.ch));
      end
   end
endmodule

/* tb_timer_irq_dma_enable_status.sv */
// Self-checking bench for the timer interrupt and DMA enable bank
`timescale 1ns/1ps
module tb_timer_irq_dma_enable_status;
   import timer_irq_pkg::*;
   logic          sys_clk, timer_irq, host_irq;
   logic          srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]    reg_addr = 8'h00, n_upd, n_trig, n_ch;
   logic [15:0]   reg_wdata = 16'h0000, reg_rdata;
   logic [3:0]    mode = 4'h0;
   timer_events_s events = '0;
   dma_req_s      dma_req;
   int            n_mismatch = 0, checks_done = 0;
   timer_irq_dma_enable_status i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .events(events), .ch_input_mode(mode), .timer_irq(timer_irq), .dma_req(dma_req),
      .host_irq(host_irq));
   dma_sink_model i_sink (.sys_clk(sys_clk), .srst(srst), .dma_req(dma_req),
      .n_upd(n_upd), .n_trig(n_trig), .n_ch(n_ch));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task ev(input logic u, input logic t, input logic [3:0] c, input logic [3:0] m,
           input logic [3:0] r);
      @(posedge sys_clk);
      events <= '{u, t, c, m, r};
      @(posedge sys_clk);
      events <= '0;
   endtask
   task wait_chk_irq(input logic e);
      repeat (3) @(posedge sys_clk);
      #1 chk({15'h0000, timer_irq}, {15'h0000, e});
   endtask
   task t_regs();
      rd(enable_offset, 16'h0000);
      rd(status_offset, 16'h0000);
      wr(enable_offset, 16'hffff);
      rd(enable_offset, 16'h5f5f);
      rd(8'h20, 16'h0000);
      wr(enable_offset, 16'h0000);
   endtask
   // Gated DMA requests, on then off
   task t_dma();
      wr(enable_offset, 16'h5f00);
      ev(1'b1, 1'b1, 4'h0, 4'hf, 4'h0);
      wait_chk_irq(1'b0);
      wr(enable_offset, 16'h0000);
      ev(1'b1, 1'b1, 4'h0, 4'hf, 4'h0);
      repeat (2) @(posedge sys_clk);
      #1 chk({n_upd, n_trig}, 16'h0101);
      chk({8'h00, n_ch}, 16'h0004);
      rd(status_offset, 16'h005f);
      wr(enable_offset, 16'h005f);
      wait_chk_irq(1'b1);
      wr(status_offset, 16'h0000);
      wait_chk_irq(1'b0);
   endtask
   // Second capture while flag set marks overcapture
   task t_ovc();
      @(posedge sys_clk);
      mode <= 4'hf;
      ev(1'b1, 1'b1, 4'hf, 4'h0, 4'h0);
      ev(1'b0, 1'b0, 4'hf, 4'h0, 4'h0);
      rd(status_offset, 16'h1e5f);
      ev(1'b0, 1'b0, 4'h0, 4'h0, 4'hf);
      rd(status_offset, 16'h1e41);
      wait_chk_irq(1'b1);
      wr(status_offset, 16'h0000);
      rd(status_offset, 16'h0000);
      wr(enable_offset, 16'h0000);
   endtask
   // Block interrupt raised, masked and cleared
   task t_host();
      rd(hostirq_offset, 16'h0003);
      wr(hostmsk_offset, 16'h0003);
      repeat (3) @(posedge sys_clk);
      #1 chk({15'h0000, host_irq}, 16'h0001);
      wr(hostmsk_offset, 16'h0000);
      repeat (3) @(posedge sys_clk);
      #1 chk({15'h0000, host_irq}, 16'h0000);
      wr(hostirq_offset, 16'h0003);
      rd(hostirq_offset, 16'h0000);
   endtask
   task results();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      results();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_dma();
      t_ovc();
      t_host();
      results();
   end
endmodule
